// >>> verilog/mocs_map.svh
// Offsets, field positions, reset values and thresholds of the statistics bank
`ifndef MOCS_MAP_SVH
`define MOCS_MAP_SVH
`define MOCS_OFF_RX_OCTETS 8'hA8
`define MOCS_OFF_TX_OCTETS 8'hD0
`define MOCS_OFF_ONE_COL 8'hF0
`define MOCS_CNT_RESET 32'h0000_0000
`define MOCS_THRESHOLD 32'hC000_0000
`define MOCS_MASK_RX_BIT 0
`define MOCS_MASK_TX_BIT 1
`define MOCS_MASK_COL_BIT 2
`define MOCS_VLAN_OCTETS 16'h0004
`endif

// >>> verilog/mocs_pkg.sv
// Types shared by the statistics bank files
package mocs_pkg;
   typedef logic [31:0] mocs_word_t;
   typedef logic [15:0] mocs_len_t;
   typedef logic [7:0] mocs_addr_t;
endpackage

// >>> verilog/mocs_counter.sv
// One 32-bit wrapping statistics counter with host load and threshold event
`timescale 1ns/1ps
`default_nettype none
`include "mocs_map.svh"
module mocs_counter
   import mocs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Counting
   input wire logic cnt_en,
   input wire mocs_word_t cnt_add,
   // Host load
   input wire logic load_en,
   input wire mocs_word_t load_val,
   // State
   output logic [31:0] count_q,
   output logic hit_q
);
   mocs_word_t count_d;

   // Host write beats a coincident increment; sum wraps naturally
   always_comb
   begin
      count_d = count_q;
      if (load_en)
         count_d = load_val;
      else if (cnt_en)
         count_d = count_q + cnt_add;
   end

   // Counter and registered pulse when a count lands exactly on the threshold
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_q <= `MOCS_CNT_RESET;
         hit_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         // Only counting reaching the threshold raises it, not a load
         hit_q <= cnt_en && !load_en && (count_q != `MOCS_THRESHOLD)
                  && (count_d == `MOCS_THRESHOLD);
      end
   end

   a_wrap_exact: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (cnt_en && !load_en) |=> count_q == $past(count_q) + $past(cnt_add))
      else $error("counter did not add its increment");
   a_load_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
      load_en |=> count_q == $past(load_val))
      else $error("host load not taken");
endmodule
`default_nettype wire

// >>> verilog/mocs_bank.sv
// Octet and single-collision statistics counter bank with host access
//
// Overview of operation
// - Add octets of every good received frame
// - Skip long, FCS, length, alignment, overrun frames
// - Add octets of every good transmitted frame
// - Count frames sent after exactly one collision
// - Counters are 32 bits and wrap
// - Octet counts include four VLAN tag octets
// - Reaching threshold sets statistics update event; the code needs a count to land exactly on it, not step past it
// - Count only if globally on and unmasked
`timescale 1ns/1ps
`default_nettype none
`include "mocs_map.svh"
module mocs_bank
   import mocs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Host register port
   input wire mocs_pkg::mocs_addr_t host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire mocs_pkg::mocs_word_t host_wdata,
   output logic [31:0] host_rdata_q,
   output logic host_rvalid_q,
   // Control bits from the MAC control and mask registers
   input wire logic counters_global_on,
   input wire logic [2:0] counter_disable_mask,
   // Receive frame status
   input wire logic rx_done,
   input wire mocs_pkg::mocs_len_t rx_len,
   input wire logic rx_vlan_stripped,
   input wire logic rx_too_long,
   input wire logic rx_fcs_err,
   input wire logic rx_len_err,
   input wire logic rx_align_err,
   input wire logic rx_overrun,
   // Transmit frame status
   input wire logic tx_done,
   input wire logic tx_ok,
   input wire mocs_pkg::mocs_len_t tx_len,
   input wire logic tx_vlan_inserted,
   input wire logic [4:0] tx_collisions,
   // Event toward the interrupt cause register
   output logic stats_rollover_event
);
   import mocs_pkg::*;

   // ------------------------------------------------------------
   // Frame qualification
   // ------------------------------------------------------------
   logic rx_good;
   logic tx_good;
   logic col_one;
   logic rx_en;
   logic tx_en;
   logic col_en;
   mocs_word_t rx_add;
   mocs_word_t tx_add;
   logic [31:0] rx_cnt;
   logic [31:0] tx_cnt;
   logic [31:0] col_cnt;
   logic rx_hit;
   logic tx_hit;
   logic col_hit;

   // Errored or overrun receive frames never reach the count
   assign rx_good = rx_done && !(rx_too_long || rx_fcs_err || rx_len_err
                    || rx_align_err || rx_overrun);
   assign tx_good = tx_done && tx_ok;
   assign col_one = tx_good && (tx_collisions == 5'h01);

   // Gating by global enable and per-counter mask
   assign rx_en = rx_good && counters_global_on
                  && !counter_disable_mask[`MOCS_MASK_RX_BIT];
   assign tx_en = tx_good && counters_global_on
                  && !counter_disable_mask[`MOCS_MASK_TX_BIT];
   assign col_en = col_one && counters_global_on
                   && !counter_disable_mask[`MOCS_MASK_COL_BIT];

   // A tag the MAC removed or added is still counted as on the wire
   // Sum is taken at full width so a long length plus the tag never wraps at 16 bits
   assign rx_add = {16'h0000, rx_len}
                   + (rx_vlan_stripped ? {16'h0000, `MOCS_VLAN_OCTETS} : 32'h0000_0000);
   assign tx_add = {16'h0000, tx_len}
                   + (tx_vlan_inserted ? {16'h0000, `MOCS_VLAN_OCTETS} : 32'h0000_0000);

   // ------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------
   logic wr_rx;
   logic wr_tx;
   logic wr_col;
   assign wr_rx = host_wr && (host_addr == `MOCS_OFF_RX_OCTETS);
   assign wr_tx = host_wr && (host_addr == `MOCS_OFF_TX_OCTETS);
   assign wr_col = host_wr && (host_addr == `MOCS_OFF_ONE_COL);

   mocs_counter u_rx
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .cnt_en(rx_en),
      .cnt_add(rx_add),
      .load_en(wr_rx),
      .load_val(host_wdata),
      .count_q(rx_cnt),
      .hit_q(rx_hit)
   );

   mocs_counter u_tx
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .cnt_en(tx_en),
      .cnt_add(tx_add),
      .load_en(wr_tx),
      .load_val(host_wdata),
      .count_q(tx_cnt),
      .hit_q(tx_hit)
   );

   mocs_counter u_col
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .cnt_en(col_en),
      .cnt_add(32'h0000_0001),
      .load_en(wr_col),
      .load_val(host_wdata),
      .count_q(col_cnt),
      .hit_q(col_hit)
   );

   // ------------------------------------------------------------
   // Event and read path
   // ------------------------------------------------------------
   // One-cycle pulse; the cause register outside holds it sticky
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         stats_rollover_event <= 1'b0;
      else
         stats_rollover_event <= rx_hit || tx_hit || col_hit;
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         host_rdata_q <= 32'h0000_0000;
         host_rvalid_q <= 1'b0;
      end
      else
      begin
         host_rvalid_q <= host_rd;
         if (host_rd)
         begin
            unique case (host_addr)
               `MOCS_OFF_RX_OCTETS: host_rdata_q <= rx_cnt;
               `MOCS_OFF_TX_OCTETS: host_rdata_q <= tx_cnt;
               `MOCS_OFF_ONE_COL: host_rdata_q <= col_cnt;
               default: host_rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_bad_rx;
      rx_done && (rx_too_long || rx_fcs_err || rx_len_err || rx_align_err || rx_overrun);
   endsequence
   sequence s_quiet_host;
      !wr_rx;
   endsequence

   a_rx_error_skip: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (s_bad_rx and s_quiet_host) |=> rx_cnt == $past(rx_cnt))
      else $error("errored receive frame was counted");
   a_rx_octet_add: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rx_en && !wr_rx) |=> rx_cnt == $past(rx_cnt) + {16'h0000, $past(rx_len)}
         + ($past(rx_vlan_stripped) ? 32'h0000_0004 : 32'h0000_0000))
      else $error("receive octets not added");
   a_tx_octet_add: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (tx_en && !wr_tx) |=> tx_cnt == $past(tx_cnt) + {16'h0000, $past(tx_len)}
         + ($past(tx_vlan_inserted) ? 32'h0000_0004 : 32'h0000_0000))
      else $error("transmit octets not added");
   a_vlan_tag_add: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (tx_en && !wr_tx && tx_vlan_inserted && tx_len == 16'h0000)
         |=> tx_cnt == $past(tx_cnt) + 32'h0000_0004)
      else $error("VLAN tag octets missing");
   a_one_collision: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (!wr_col) |=> col_cnt == $past(col_cnt) + {31'h0, $past(col_en)})
      else $error("single collision count wrong");
   a_gate_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (!counters_global_on && !host_wr) |=> $stable(rx_cnt) && $stable(tx_cnt)
         && $stable(col_cnt))
      else $error("counter moved while disabled");
   a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (col_en && !wr_col && col_cnt == 32'hFFFF_FFFF) |=> col_cnt == 32'h0)
      else $error("counter failed to wrap");
   a_event_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (col_en && !wr_col && col_cnt == 32'hBFFF_FFFF) |=> ##1 stats_rollover_event)
      else $error("threshold event missing");
   a_host_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_rx |=> rx_cnt == $past(host_wdata))
      else $error("host write not loaded");
   a_read_valid: assert property (@(posedge ref_clk) disable iff (!arst_n)
      host_rd |=> host_rvalid_q)
      else $error("read valid missing");
   a_read_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !host_rd |=> !host_rvalid_q)
      else $error("read valid without strobe");
   a_read_rx: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (host_rd && host_addr == `MOCS_OFF_RX_OCTETS) |=> host_rdata_q == $past(rx_cnt))
      else $error("receive count read wrong");
   a_rx_event: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rx_en && !wr_rx && rx_cnt != 32'hC000_0000 && rx_cnt + rx_add == 32'hC000_0000)
         |=> ##1 stats_rollover_event)
      else $error("receive threshold event missing");
endmodule
`default_nettype wire

// >>> verification/mocs_mac_model.sv
// Behavioural MAC frame status source for the statistics bank bench
`timescale 1ns/1ps
`default_nettype none
module mocs_mac_model
   import mocs_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Receive status
   output logic rx_done,
   output mocs_pkg::mocs_len_t rx_len,
   output logic rx_tag,
   output logic [4:0] rx_err,
   // Transmit status
   output logic tx_done,
   output logic tx_ok,
   output mocs_pkg::mocs_len_t tx_len,
   output logic tx_tag,
   output logic [4:0] tx_col
);
   // Idle: no frame finishing
   initial
   begin
      {rx_done, rx_len, rx_tag, rx_err} = '0;
      {tx_done, tx_ok, tx_len, tx_tag, tx_col} = '0;
   end
   // One-cycle pulse; length inverted after so a stale value never looks valid
   task automatic rx(input mocs_len_t n, input logic t, input logic [4:0] e);
      @(posedge ref_clk);
      {rx_done, rx_len, rx_tag, rx_err} <= {1'b1, n, t, e};
      @(posedge ref_clk);
      {rx_done, rx_len} <= {1'b0, ~n};
   endtask
   task automatic tx(input logic ok, input mocs_len_t n, input logic t, input logic [4:0] c);
      @(posedge ref_clk);
      {tx_done, tx_ok, tx_len, tx_tag, tx_col} <= {1'b1, ok, n, t, c};
      @(posedge ref_clk);
      {tx_done, tx_len} <= {1'b0, ~n};
   endtask
endmodule
`default_nettype wire

// >>> verification/mocs_bank_tb.sv
// Self-checking bench for the octet and collision statistics bank
`timescale 1ns/1ps
`default_nettype none
module mocs_bank_tb;
   import mocs_pkg::*;
   logic ref_clk, arst_n, host_wr, host_rd, counters_global_on, rx_done, rx_tag;
   logic tx_done, tx_ok, tx_tag, host_rvalid_q, stats_rollover_event;
   logic [2:0] counter_disable_mask, on;
   logic [4:0] rx_err, tx_col;
   logic [31:0] host_rdata_q;
   mocs_addr_t host_addr;
   mocs_word_t host_wdata, er, et, ec;
   mocs_len_t rx_len, tx_len;
   int n_fail = 0;
   int checked = 0;
   // Design and frame status source
   mocs_bank u_mocs_bank (.ref_clk(ref_clk), .arst_n(arst_n), .host_addr(host_addr),
      .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
      .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
      .counters_global_on(counters_global_on), .counter_disable_mask(counter_disable_mask),
      .rx_done(rx_done), .rx_len(rx_len), .rx_vlan_stripped(rx_tag),
      .rx_too_long(rx_err[0]), .rx_fcs_err(rx_err[1]), .rx_len_err(rx_err[2]),
      .rx_align_err(rx_err[3]), .rx_overrun(rx_err[4]), .tx_done(tx_done), .tx_ok(tx_ok),
      .tx_len(tx_len), .tx_vlan_inserted(tx_tag), .tx_collisions(tx_col),
      .stats_rollover_event(stats_rollover_event));
   mocs_mac_model u_mocs_mac_model (.ref_clk(ref_clk), .rx_done(rx_done), .rx_len(rx_len),
      .rx_tag(rx_tag), .rx_err(rx_err), .tx_done(tx_done), .tx_ok(tx_ok), .tx_len(tx_len),
      .tx_tag(tx_tag), .tx_col(tx_col));
   // 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Host write: one-cycle strobe
   task automatic wr(input mocs_addr_t a, input mocs_word_t d);
      @(posedge ref_clk);
      {host_addr, host_wdata, host_wr} <= {a, d, 1'b1};
      @(posedge ref_clk);
      host_wr <= 1'b0;
   endtask
   // Host read: answer stands one cycle, so look just after the edge
   task automatic rd(input mocs_addr_t a, input mocs_word_t e);
      @(posedge ref_clk);
      {host_addr, host_rd} <= {a, 1'b1};
      @(posedge ref_clk);
      host_rd <= 1'b0;
      #1;
      chk("rvalid", 32'h1, {31'h0, host_rvalid_q});
      chk("rdata", e, host_rdata_q);
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Tests need about 125 cycles; far longer means a hang
   initial
   begin
      #100000;
      n_fail++;
      print_verdict();
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      {arst_n, host_wr, host_rd, host_addr, host_wdata} = '0;
      counters_global_on = 1'b1;
      counter_disable_mask = 3'h0;
      {er, et, ec} = {32'hA4, 32'h7C, 32'h1};
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(8'hA8, 32'h0);
      rd(8'hD0, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h0);
      u_mocs_mac_model.rx(16'h003C, 1'b1, 5'h0);
      u_mocs_mac_model.rx(16'h0064, 1'b0, 5'h0);
      for (int i = 0; i < 5; i++)
         u_mocs_mac_model.rx(16'h0032, 1'b0, 5'h1 << i);
      rd(8'hA8, er);
      u_mocs_mac_model.tx(1'b1, 16'h003C, 1'b1, 5'h1);
      u_mocs_mac_model.tx(1'b1, 16'h003C, 1'b0, 5'h2);
      u_mocs_mac_model.tx(1'b0, 16'h003C, 1'b0, 5'h1);
      rd(8'hD0, et);
      rd(8'hF0, ec);
      // Mask each counter alone, then global off with no mask
      for (int i = 0; i < 4; i++)
      begin
         on = (i < 3) ? ~(3'h1 << i) : 3'h0;
         @(posedge ref_clk);
         counters_global_on <= (i < 3);
         counter_disable_mask <= 3'h1 << i;
         u_mocs_mac_model.rx(16'h0040, 1'b0, 5'h0);
         u_mocs_mac_model.tx(1'b1, 16'h0040, 1'b0, 5'h1);
         er += on[0] ? 32'h40 : 32'h0;
         et += on[1] ? 32'h40 : 32'h0;
         ec += on[2] ? 32'h1 : 32'h0;
         rd(8'hA8, er);
         rd(8'hD0, et);
         rd(8'hF0, ec);
      end
      @(posedge ref_clk);
      {counters_global_on, counter_disable_mask} <= 4'h8;
      wr(8'hF0, 32'hFFFFFFFF);
      u_mocs_mac_model.tx(1'b1, 16'h0000, 1'b0, 5'h1);
      rd(8'hF0, 32'h0);
      wr(8'hA8, 32'hBFFFFFC0);
      rd(8'hA8, 32'hBFFFFFC0);
      u_mocs_mac_model.rx(16'h003C, 1'b1, 5'h0);
      #1 chk("event early", 32'h0, {31'h0, stats_rollover_event});
      @(posedge ref_clk);
      #1 chk("event", 32'h1, {31'h0, stats_rollover_event});
      @(posedge ref_clk);
      #1 chk("event end", 32'h0, {31'h0, stats_rollover_event});
      rd(8'hA8, 32'hC0000000);
      // Collision counter landing on the threshold; tag alone adds four octets
      wr(8'hF0, 32'hBFFFFFFF);
      u_mocs_mac_model.tx(1'b1, 16'h0000, 1'b1, 5'h1);
      #1 chk("col event early", 32'h0, {31'h0, stats_rollover_event});
      @(posedge ref_clk);
      #1 chk("col event", 32'h1, {31'h0, stats_rollover_event});
      rd(8'hF0, 32'hC0000000);
      rd(8'hD0, et + 32'h4);
      print_verdict();
   end
endmodule
`default_nettype wire
